// file: src/sbwm_defs.vh
`ifndef SBWM_DEFS_VH
`define SBWM_DEFS_VH
// lane geometry
`define SBWM_LANE_W 9
`define SBWM_LANES_X18 2
`define SBWM_LANES_X36 4
// beats per burst and cycle offsets after the address cycle
`define SBWM_BEATS 4
`define SBWM_BEAT_CNT_W 2
`define SBWM_FIRST_CYC 1
`define SBWM_LAST_BEAT 2'h3
`define SBWM_ZERO_BEAT 2'h0
`define SBWM_BEAT_STEP 2'h1
// memory depth defaults
`define SBWM_ADDR_W 6
`endif

// file: src/sbwm_skid.v
`timescale 1ns/1ns
`default_nettype none
// two-entry buffer, valid/ready both sides, full throughput
module sbwm_skid #(
	parameter W = 8
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// fill side
	input wire i_valid,
	input wire [W-1:0] i_data,
	output wire o_ready,
	// drain side
	output wire o_valid,
	output wire [W-1:0] o_data,
	input wire i_ready
);
	reg [W-1:0] mem_reg [0:1];
	reg wr_ptr_reg;
	reg rd_ptr_reg;
	reg [1:0] cnt_reg;
	wire push;
	wire pop;

	// honest full and empty from the occupancy count
	assign o_ready = (cnt_reg != 2'h2);
	assign o_valid = (cnt_reg != 2'h0);
	assign o_data = mem_reg[rd_ptr_reg];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;

	// storage has no reset, data is qualified by count
	always @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_data;
		end
	end

	// pointers and count
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			case ({push, pop})
				2'b10: cnt_reg <= cnt_reg + 2'h1;
				2'b01: cnt_reg <= cnt_reg - 2'h1;
				default: cnt_reg <= cnt_reg;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: src/sbwm_write_port.v
// Notes on behaviour
// - x18: both selects low, all 18 bits written
// - x18: select0 only, bits 8-0 written
// - x18: select1 only, bits 17-9 written
// - x18: both selects high, nothing written
// - x36: all selects low, all 36 written
// - x36: each low select writes its lane
// - x36: all selects high, memory unchanged
// - selects apply per beat independently
// - data and selects taken each beat edge
// - four beats to A..A+3 after address
`timescale 1ns/1ns
`include "sbwm_defs.vh"
`default_nettype none
// write port of a burst sram with byte-lane masking; the two input clock
// edges are folded into one fabric clock, so i_beat_valid marks each beat
module sbwm_write_port #(
	parameter LANES = `SBWM_LANES_X36,
	parameter ADDR_W = `SBWM_ADDR_W
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// write address cycle
	input wire i_wr_start,
	input wire [ADDR_W-1:0] i_wr_addr,
	// data beats, one per input clock rise
	input wire i_beat_valid,
	input wire [LANES*`SBWM_LANE_W-1:0] i_wr_data,
	input wire [LANES-1:0] i_byte_lane_write_select_n,
	// readback for checking stored words
	input wire i_rd_en,
	input wire [ADDR_W-1:0] i_rd_addr,
	output reg [LANES*`SBWM_LANE_W-1:0] o_rd_data,
	output reg o_rd_valid,
	// status
	output reg o_burst_busy,
	output reg o_beat_ready
);
	localparam DW = LANES * `SBWM_LANE_W;
	localparam BW = DW + LANES + ADDR_W;
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DATA = 2'h2;

	reg [DW-1:0] mem_reg [0:(1<<ADDR_W)-1];
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [ADDR_W-1:0] base_reg;
	reg [`SBWM_BEAT_CNT_W-1:0] beat_reg;
	reg [`SBWM_BEAT_CNT_W-1:0] beat_next;
	wire take_beat;
	wire buf_ready;
	wire buf_valid;
	wire [BW-1:0] buf_out;
	wire [DW-1:0] buf_data;
	wire [LANES-1:0] buf_sel_n;
	wire [ADDR_W-1:0] buf_addr;
	wire [ADDR_W-1:0] beat_addr;
	wire [DW-1:0] old_word;
	wire [DW-1:0] new_word;
	integer k;

	// expand active-low lane selects to a bit mask, lane n is bits 9n+8..9n
	function [DW-1:0] lane_mask;
		input [LANES-1:0] sel_n;
		integer n;
		begin
			lane_mask = {DW{1'b0}};
			for (n = 0; n < DW; n = n + 1) begin
				lane_mask[n] = ~sel_n[n / `SBWM_LANE_W];
			end
		end
	endfunction

	// burst address: base plus beat offset, wrapping in the address width
	function [ADDR_W-1:0] burst_addr;
		input [ADDR_W-1:0] base;
		input [`SBWM_BEAT_CNT_W-1:0] beat;
		begin
			burst_addr = base + {{(ADDR_W-`SBWM_BEAT_CNT_W){1'b0}}, beat};
		end
	endfunction

	// burst sequencing
	// data comes in the cycles after the address cycle; the wait state is
	// never entered, start goes straight to the data state for t+1
	always @* begin
		state_next = state_reg;
		beat_next = beat_reg;
		case (state_reg)
			ST_IDLE: begin
				if (i_wr_start) begin
					state_next = ST_DATA;
					beat_next = `SBWM_ZERO_BEAT;
				end
			end
			ST_WAIT: begin
				state_next = ST_DATA;
			end
			ST_DATA: begin
				if (take_beat) begin
					beat_next = beat_reg + `SBWM_BEAT_STEP;
					if (beat_reg == `SBWM_LAST_BEAT) begin
						state_next = ST_IDLE;
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// a beat is taken when one is offered in the data phase and the buffer has room
	assign take_beat = (state_reg == ST_DATA) & i_beat_valid & buf_ready;
	assign beat_addr = burst_addr(base_reg, beat_reg);

	// sequencer registers and registered status outputs
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
			beat_reg <= `SBWM_ZERO_BEAT;
			base_reg <= {ADDR_W{1'b0}};
			o_burst_busy <= 1'b0;
			o_beat_ready <= 1'b0;
		end else begin
			state_reg <= state_next;
			beat_reg <= beat_next;
			if ((state_reg == ST_IDLE) && i_wr_start) begin
				base_reg <= i_wr_addr;
			end
			o_burst_busy <= (state_next != ST_IDLE);
			o_beat_ready <= (state_next == ST_DATA);
		end
	end

	// buffer between beat capture and array update, absorbs a stall
	sbwm_skid #(
		.W(BW)
	) u_buf (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_valid(take_beat),
		.i_data({beat_addr, i_byte_lane_write_select_n, i_wr_data}),
		.o_ready(buf_ready),
		.o_valid(buf_valid),
		.o_data(buf_out),
		.i_ready(~i_rd_en)
	);

	assign buf_data = buf_out[DW-1:0];
	assign buf_sel_n = buf_out[DW+LANES-1:DW];
	assign buf_addr = buf_out[BW-1:DW+LANES];
	assign old_word = mem_reg[buf_addr];

	// each beat carries its own selects through the buffer
	// lanes with low select take new data
	// all selects high leaves old word intact
	assign new_word = (buf_data & lane_mask(buf_sel_n)) | (old_word & ~lane_mask(buf_sel_n));

	// array update; a read has priority so the buffer drains afterwards
	always @(posedge i_clk) begin
		if (buf_valid && !i_rd_en) begin
			mem_reg[buf_addr] <= new_word;
		end
	end

	// readback path, registered
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= {DW{1'b0}};
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
			if (i_rd_en) begin
				o_rd_data <= mem_reg[i_rd_addr];
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/sbwm_write_port_props.sv
`timescale 1ns/1ns
`default_nettype none
// handshake timing seen at the write port pins
module sbwm_write_port_props (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// inputs
	input wire logic i_wr_start,
	input wire logic i_beat_valid,
	input wire logic i_rd_en,
	// outputs
	input wire logic o_rd_valid,
	input wire logic o_burst_busy,
	input wire logic o_beat_ready
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// start opens the beat window
	AST_START: assert property (!o_burst_busy && i_wr_start |=> o_beat_ready)
		else $error("no beats after start");
	AST_IDLE: assert property (!o_burst_busy && !i_wr_start |=> !o_burst_busy)
		else $error("busy without start");
	AST_BUSY4: assert property ($rose(o_burst_busy) |-> o_burst_busy [*4])
		else $error("burst shorter than four beats");
	AST_FOUR: assert property ($rose(o_beat_ready) ##0 (i_beat_valid && !i_rd_en) [*4]
		|=> !o_beat_ready)
		else $error("window open after four beats");
	AST_END: assert property ($fell(o_burst_busy) |-> $past(i_beat_valid))
		else $error("burst closed without beat");
	AST_RB: assert property (o_beat_ready |-> o_burst_busy)
		else $error("ready outside burst");
	AST_RDV: assert property (i_rd_en |=> o_rd_valid)
		else $error("read not answered");
	AST_RDV0: assert property (!i_rd_en |=> !o_rd_valid)
		else $error("read valid without request");
endmodule
bind sbwm_write_port sbwm_write_port_props i_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_wr_start(i_wr_start), .i_beat_valid(i_beat_valid), .i_rd_en(i_rd_en),
	.o_rd_valid(o_rd_valid), .o_burst_busy(o_burst_busy), .o_beat_ready(o_beat_ready));
`default_nettype wire

// file: tb/sbwm_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// controller side: address cycle, then four beats back to back
module sbwm_ctl_model (
	// clock
	input wire logic i_clk,
	// write port drive
	output logic o_start,
	output logic [5:0] o_addr,
	output logic o_valid,
	output logic [35:0] o_data,
	output logic [3:0] o_sel_n
);
	integer i;
	// quiet bus at time zero
	initial begin
		{o_start, o_addr, o_valid, o_data, o_sel_n} = '0;
	end
	task automatic burst(input logic [5:0] a, input logic [143:0] d, input logic [15:0] s);
		@(negedge i_clk);
		o_start = 1'b1;
		o_addr = a;
		for (i = 0; i < 4; i++) begin
			@(negedge i_clk);
			o_start = 1'b0;
			o_valid = 1'b1;
			o_data = d[36*i +: 36];
			o_sel_n = s[4*i +: 4];
		end
		@(negedge i_clk);
		o_valid = 1'b0;
		// released data and address lines flip so stale data cannot pass
		o_data = ~o_data;
		o_addr = ~a;
	endtask
endmodule
`default_nettype wire

// file: tb/sbwm_write_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sbwm_write_port_tb_top;
	logic clk, rst_b, st, bv, rd_en, rd_v, busy, rdy;
	logic [5:0] ad, rd_addr;
	logic [35:0] wd, rd_d;
	logic [3:0] sel_n;
	logic [35:0] exp_mem [0:63];
	// x18 copy shares the lower two lanes of the same stimulus
	logic rd_v18, busy18, rdy18;
	logic [17:0] rd_d18;
	integer fail_count = 0;
	integer checked = 0;
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	sbwm_ctl_model i_ctl (.i_clk(clk), .o_start(st), .o_addr(ad), .o_valid(bv),
		.o_data(wd), .o_sel_n(sel_n));
	sbwm_write_port #(.LANES(4), .ADDR_W(6)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
		.i_wr_start(st), .i_wr_addr(ad), .i_beat_valid(bv), .i_wr_data(wd),
		.i_byte_lane_write_select_n(sel_n), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
		.o_rd_data(rd_d), .o_rd_valid(rd_v), .o_burst_busy(busy), .o_beat_ready(rdy));
	sbwm_write_port #(.LANES(2), .ADDR_W(6)) i_dut18 (.i_clk(clk), .i_rst_b(rst_b),
		.i_wr_start(st), .i_wr_addr(ad), .i_beat_valid(bv), .i_wr_data(wd[17:0]),
		.i_byte_lane_write_select_n(sel_n[1:0]), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
		.o_rd_data(rd_d18), .o_rd_valid(rd_v18), .o_burst_busy(busy18),
		.o_beat_ready(rdy18));
	task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	function automatic logic [143:0] pat(input logic [35:0] b);
		pat = {b + 36'h3, b + 36'h2, b + 36'h1, b};
	endfunction
	// expected words merge only lanes whose select is low
	task automatic wr(input logic [5:0] a, input logic [143:0] d, input logic [15:0] s);
		for (int k = 0; k < 4; k++)
			for (int j = 0; j < 36; j++)
				if (!s[4*k + j/9])
					exp_mem[(a + k) % 64][j] = d[36*k + j];
		i_ctl.burst(a, d, s);
		@(negedge clk);
	endtask
	// read back four words, wrapping in the address space
	task automatic rd4(input logic [5:0] a);
		logic [5:0] w;
		for (int k = 0; k < 4; k++) begin
			w = a + 6'(k);
			@(negedge clk);
			rd_en = 1'b1;
			rd_addr = w;
			@(negedge clk);
			rd_en = 1'b0;
			rd_addr = ~w;
			cmp("rd_valid", 36'h1, {35'h0, rd_v});
			cmp("rd_data", exp_mem[w], rd_d);
			cmp("rd_valid18", 36'h1, {35'h0, rd_v18});
			cmp("rd_data18", {18'h0, exp_mem[w][17:0]}, {18'h0, rd_d18});
		end
	endtask
	task automatic t_full();
		wr(6'h00, pat(36'h1_2345_6789), 16'h0000);
		wr(6'h3C, pat(36'h0_0F0F_0F0F), 16'h0000);
		rd4(6'h00);
		rd4(6'h3C);
		$display("t_full done");
	endtask
	task automatic t_mask();
		wr(6'h00, pat(36'hE_DCBA_9876), 16'hBDEF);
		rd4(6'h00);
		$display("t_mask done");
	endtask
	task automatic t_wrap();
		wr(6'h3E, pat(36'h5_5555_5555), 16'h7F07);
		rd4(6'h3E);
		$display("t_wrap done");
	endtask
	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		{rst_b, rd_en, rd_addr} = '0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		t_full();
		t_mask();
		t_wrap();
		final_report();
	end
endmodule
`default_nettype wire
